//--- rtl/urxe_channel.sv
// Contract
// - space sampled at stop bit time sets framing error, status bit 6
// - failed parity check on a complete character sets status bit 5
// - fifo full, shift register holding, new data overwrites; set overrun bit 4
// - all-space character with space at stop sample is a break; status bit 7
// - break loads one break character; no more loading until line marks
// - change-in-break flagged at break start and at return to mark
// - receiver ready while fifo holds at least one unread character
// - fifo full when no free slot remains until the cpu reads
// - mode one bit 6 picks ready or full as receive interrupt source
// - receive interrupt request only when its mask bit is set
// - pointer rewinds to mode one; any mode one access advances to two
// - mode one bit 7 negates request to send while fifo is full
// - mode one bit 5: flags of top character, or accumulated since error reset
// - bits 4:3 parity handling, check only with or forced; bit 2 odd
// - bits 1:0 give five to eight data bits per character
// - mode two bits 7:6 select normal, echo, local or remote loop
// - mode two bits 3:0 set transmit stop length in sixteenth steps
// - mode two bit 4 makes transmitter wait for clear to send
// - mode two bit 5 drops request to send one bit after transmit empty
`timescale 1ns/1ps
module urxe_channel #(
  parameter int FIFO_DEPTH = urxe_pkg::FIFO_DEPTH
) (
  input  wire logic        i_sys_clk,        // system clock, 200 MHz
  input  wire logic        i_rst_n,          // async reset, active low
  input  wire logic        i_ce,             // clock enable, freezes all state
  input  wire logic        i_rx_tick16,      // 16x receive clock enable pulse
  input  wire logic        i_serial_rx_input,// serial input pin, async
  output logic             o_request_to_send_n, // receiver flow control, low = send
  output logic             o_rx_irq,         // masked receive interrupt request
  output logic             o_brk_irq,        // masked change-in-break request
  output logic [7:0]       o_channel_mode_secondary, // to transmit side
  // AXI4-Lite slave
  input  wire logic [7:0]  i_awaddr,         // write address
  input  wire logic        i_awvalid,        // write address valid
  output logic             o_awready,        // write address ready
  input  wire logic [31:0] i_wdata,          // write data
  input  wire logic [3:0]  i_wstrb,          // write strobes
  input  wire logic        i_wvalid,         // write data valid
  output logic             o_wready,         // write data ready
  output logic [1:0]       o_bresp,          // write response
  output logic             o_bvalid,         // write response valid
  input  wire logic        i_bready,         // write response ready
  input  wire logic [7:0]  i_araddr,         // read address
  input  wire logic        i_arvalid,        // read address valid
  output logic             o_arready,        // read address ready
  output logic [31:0]      o_rdata,          // read data
  output logic [1:0]       o_rresp,          // read response
  output logic             o_rvalid,         // read data valid
  input  wire logic        i_rready          // read data ready
);
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } urxe_rx_state_t;

  // ==========================================================================
  // registers
  logic [7:0] mode_primary_r, mode_secondary_r;
  logic       ptr_second_r;
  logic [7:0] int_mask_r;
  logic       brk_chg_r, overrun_r;
  logic [2:0] acc_err_r;           // block-mode accumulated brk/frame/parity
  logic       rx_meta_r, rx_sync_r;
  urxe_rx_state_t rx_state_r;
  logic [3:0] sub_r, bit_r;
  logic [7:0] shift_r;
  logic       par_acc_r;
  logic       in_break_r;
  logic       brk_mark_r;           // first mark sample seen after break
  logic       held_valid_r;         // completed char waiting in shift register
  urxe_pkg::urxe_entry_t held_r;

  // ==========================================================================
  // decoded mode fields
  logic [1:0] par_mode;
  logic [3:0] nbits;
  logic       par_odd, par_check, err_block;
  assign par_mode  = mode_primary_r[urxe_pkg::MP_PAR_MODE_H:urxe_pkg::MP_PAR_MODE_L];
  assign par_odd   = mode_primary_r[urxe_pkg::MP_PAR_TYPE];
  assign par_check = (par_mode == urxe_pkg::PAR_WITH) || (par_mode == urxe_pkg::PAR_FORCE);
  assign nbits     = 4'h5 + {2'h0, mode_primary_r[urxe_pkg::MP_BITS_H:urxe_pkg::MP_BITS_L]};
  assign err_block = mode_primary_r[urxe_pkg::MP_ERR_MODE];
  // mode two is only held here; the transmitter consumes it
  assign o_channel_mode_secondary = mode_secondary_r;

  // ==========================================================================
  // input synchroniser; only the second stage is read
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else if (i_ce) begin
      rx_meta_r <= i_serial_rx_input;
      rx_sync_r <= rx_meta_r;
    end
  end

  // ==========================================================================
  // receive fifo
  logic                  fifo_push, fifo_pop, fifo_empty, fifo_full;
  urxe_pkg::urxe_entry_t fifo_top;

  urxe_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_push    (fifo_push),
    .i_din     (held_r),
    .i_pop     (fifo_pop),
    .o_top     (fifo_top),
    .o_empty   (fifo_empty),
    .o_full    (fifo_full)
  );

  // held character moves on as soon as a slot frees up
  assign fifo_push = held_valid_r && !fifo_full;

  // ==========================================================================
  // receiver sampling: start qualified at 7th sample, then one bit per 16 ticks
  logic sample_pt, char_done, stop_space, par_bad, is_break, next_par;
  assign sample_pt  = i_rx_tick16 && (sub_r == 4'(urxe_pkg::OVERSAMPLE - 1));
  assign char_done  = (rx_state_r == RX_STOP) && sample_pt;
  assign stop_space = !rx_sync_r;
  assign next_par   = par_acc_r ^ rx_sync_r;
  assign is_break   = stop_space && (shift_r == 8'h00) && !par_acc_r;
  // parity bit folded into par_acc_r (raw bit in forced mode); even sum passes for even parity
  assign par_bad    = par_check && (par_acc_r != par_odd);

  // character timing state machine
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_state_r <= RX_IDLE;
      sub_r      <= 4'h0;
      bit_r      <= 4'h0;
      shift_r    <= 8'h00;
      par_acc_r  <= 1'b0;
    end else if (i_ce && i_rx_tick16) begin
      sub_r <= sub_r + 4'h1;
      case (rx_state_r)
        RX_IDLE: begin
          sub_r <= 4'h0;
          // no new start bit while a break is still on the line
          if (!rx_sync_r && !in_break_r) rx_state_r <= RX_START;
        end
        RX_START: begin
          if (sub_r == 4'(urxe_pkg::START_SAMPLE - 1)) begin
            if (rx_sync_r) rx_state_r <= RX_IDLE;  // noise pulse
            else begin
              rx_state_r <= RX_DATA;
              sub_r      <= 4'h0;
              bit_r      <= 4'h0;
              shift_r    <= 8'h00;
              par_acc_r  <= 1'b0;
            end
          end
        end
        RX_DATA: begin
          if (sample_pt) begin
            if (bit_r < nbits) begin
              shift_r[bit_r[2:0]] <= rx_sync_r;  // lsb first
              par_acc_r           <= next_par;
            end else if (par_check) begin
              // forced mode keeps the raw parity bit, which must match mode one bit 2
              par_acc_r <= (par_mode == urxe_pkg::PAR_FORCE) ? rx_sync_r : next_par;
            end
            if (bit_r == nbits - 4'(par_check ? 0 : 1)) rx_state_r <= RX_STOP;
            bit_r <= bit_r + 4'h1;
          end
        end
        RX_STOP: if (sample_pt) rx_state_r <= RX_IDLE;
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // completed character into the shift-register holding slot
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held_valid_r <= 1'b0;
      held_r       <= '0;
    end else if (i_ce && i_rx_tick16 && char_done) begin
      // a held char not yet moved is simply overwritten
      held_valid_r <= 1'b1;
      held_r.data   <= shift_r;
      held_r.frame  <= stop_space;
      held_r.parity <= par_bad;
      held_r.brk    <= is_break;
    end else if (i_ce && fifo_push) begin
      held_valid_r <= 1'b0;
    end
  end

  // break tracking: one entry on detect, resume after line marks two ticks
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_break_r <= 1'b0;
      brk_mark_r <= 1'b0;
    end else if (i_ce && i_rx_tick16) begin
      if (char_done && is_break) begin
        in_break_r <= 1'b1;
        brk_mark_r <= 1'b0;
      end else if (in_break_r) begin
        brk_mark_r <= rx_sync_r;
        if (rx_sync_r && brk_mark_r) in_break_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // bus access strobes
  logic        wr_fire, rd_fire, wr_mode, rd_mode, cmd_wr, aw_have_r, w_have_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= urxe_pkg::ADDR_MODE_VIEW);
  endfunction

  assign o_awready = !aw_have_r && !o_bvalid;
  assign o_wready  = !w_have_r && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign wr_fire   = aw_have_r && w_have_r && !o_bvalid;
  assign rd_fire   = i_arvalid && o_arready;
  assign cmd_wr    = wr_fire && (awaddr_r == urxe_pkg::ADDR_COMMAND) && wstrb_r[0];
  assign wr_mode   = wr_fire && wstrb_r[0] &&
                     ((awaddr_r == urxe_pkg::ADDR_MODE_PRIMARY) || (awaddr_r == urxe_pkg::ADDR_MODE_SECONDARY));
  assign rd_mode   = rd_fire &&
                     ((i_araddr == urxe_pkg::ADDR_MODE_PRIMARY) || (i_araddr == urxe_pkg::ADDR_MODE_SECONDARY));
  assign fifo_pop  = rd_fire && (i_araddr == urxe_pkg::ADDR_RX_DATA);

  // write channel capture, in either order
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= urxe_pkg::AXI_OKAY;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= is_mapped(awaddr_r) ? urxe_pkg::AXI_OKAY : urxe_pkg::AXI_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // mode registers behind one pointer; both offsets reach the pointed register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_primary_r   <= urxe_pkg::MODE_PRIMARY_RST;
      mode_secondary_r <= urxe_pkg::MODE_SECONDARY_RST;
      ptr_second_r     <= 1'b0;
      int_mask_r       <= urxe_pkg::INT_MASK_RST;
    end else if (i_ce) begin
      if (wr_mode) begin
        if (ptr_second_r) mode_secondary_r <= wdata_r[7:0];
        else              mode_primary_r   <= wdata_r[7:0];
      end
      if (cmd_wr && wdata_r[urxe_pkg::CMD_PTR_REWIND]) begin
        ptr_second_r <= 1'b0;
      end else if ((wr_mode || rd_mode) && !ptr_second_r) begin
        ptr_second_r <= 1'b1;
      end
      if (wr_fire && wstrb_r[0] && (awaddr_r == urxe_pkg::ADDR_INT_MASK)) begin
        int_mask_r <= wdata_r[7:0];
      end
    end
  end

  // ==========================================================================
  // sticky flags; a setting event wins over a clear in the same cycle
  logic overrun_evt, brk_chg_evt, err_reset;
  assign overrun_evt = i_rx_tick16 && char_done && held_valid_r && fifo_full && !fifo_push;
  assign brk_chg_evt = i_rx_tick16 &&
                       ((char_done && is_break) || (in_break_r && rx_sync_r && brk_mark_r));
  assign err_reset   = cmd_wr && wdata_r[urxe_pkg::CMD_ERR_RESET];

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overrun_r <= 1'b0;
      brk_chg_r <= 1'b0;
      acc_err_r <= 3'h0;
    end else if (i_ce) begin
      if (overrun_evt)    overrun_r <= 1'b1;
      else if (err_reset) overrun_r <= 1'b0;
      if (brk_chg_evt)    brk_chg_r <= 1'b1;
      else if (cmd_wr && wdata_r[urxe_pkg::CMD_BRK_CHG_CLR]) brk_chg_r <= 1'b0;
      // flags of every character popped off the top are ORed in whatever the mode; only block mode shows them
      if (fifo_pop && !fifo_empty) begin
        acc_err_r <= acc_err_r | {fifo_top.brk, fifo_top.frame, fifo_top.parity};
      end else if (err_reset) begin
        acc_err_r <= 3'h0;
      end
    end
  end

  // ==========================================================================
  // status and interrupt view
  logic [2:0] top_err, shown_err;
  logic [7:0] status;
  logic       rx_cond;
  logic [7:0] int_status;
  assign top_err   = fifo_empty ? 3'h0 : {fifo_top.brk, fifo_top.frame, fifo_top.parity};
  assign shown_err = err_block ? (acc_err_r | top_err) : top_err;
  assign status    = {shown_err, overrun_r, 2'h0, fifo_full, !fifo_empty};
  assign rx_cond   = mode_primary_r[urxe_pkg::MP_INT_SEL] ? fifo_full : !fifo_empty;
  assign int_status = {5'h00, brk_chg_r, rx_cond, 1'b0};
  assign o_rx_irq   = rx_cond && int_mask_r[urxe_pkg::IS_RX];
  assign o_brk_irq  = brk_chg_r && int_mask_r[urxe_pkg::IS_BRK_CHG];
  // receiver flow control: drop request to send while no slot is free
  assign o_request_to_send_n = mode_primary_r[urxe_pkg::MP_RTS_CTRL] && fifo_full;

  // read data path, registered
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= urxe_pkg::AXI_OKAY;
    end else if (i_ce) begin
      if (rd_fire) begin
        o_rvalid <= 1'b1;
        o_rresp  <= is_mapped(i_araddr) ? urxe_pkg::AXI_OKAY : urxe_pkg::AXI_SLVERR;
        case (i_araddr)
          urxe_pkg::ADDR_MODE_PRIMARY,
          urxe_pkg::ADDR_MODE_SECONDARY: o_rdata <= {24'h000000, ptr_second_r ? mode_secondary_r : mode_primary_r};
          urxe_pkg::ADDR_STATUS:     o_rdata <= {24'h000000, status};
          urxe_pkg::ADDR_RX_DATA:    o_rdata <= {24'h000000, fifo_top.data};
          urxe_pkg::ADDR_INT_MASK:   o_rdata <= {24'h000000, int_mask_r};
          urxe_pkg::ADDR_INT_STATUS: o_rdata <= {24'h000000, int_status};
          urxe_pkg::ADDR_MODE_VIEW:  o_rdata <= {15'h0000, ptr_second_r, mode_secondary_r, mode_primary_r};
          default:                   o_rdata <= 32'h0000_0000;
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- rtl/urxe_fifo.sv
`timescale 1ns/1ps
module urxe_fifo #(
  parameter int DEPTH = 3
) (
  input  wire logic                 i_sys_clk,  // system clock
  input  wire logic                 i_rst_n,    // async reset, active low
  input  wire logic                 i_ce,       // clock enable
  input  wire logic                 i_push,     // write entry
  input  wire urxe_pkg::urxe_entry_t i_din,     // entry written
  input  wire logic                 i_pop,      // drop top entry
  output urxe_pkg::urxe_entry_t     o_top,      // entry at the top
  output logic                      o_empty,    // nothing stored
  output logic                      o_full      // no free slot
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  urxe_pkg::urxe_entry_t mem [DEPTH];
  logic [AW-1:0]         rd_r;
  logic [AW-1:0]         wr_r;
  logic [CW-1:0]         cnt_r;
  logic                  do_push;
  logic                  do_pop;

  // ==========================================================================
  // pointers; a push into a full fifo is dropped here, the caller flags overrun
  assign do_push = i_push && (cnt_r != CW'(DEPTH));
  assign do_pop  = i_pop && (cnt_r != '0);
  assign o_empty = (cnt_r == '0);
  assign o_full  = (cnt_r == CW'(DEPTH));
  assign o_top   = mem[rd_r];

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // storage
  always_ff @(posedge i_sys_clk) begin
    if (i_ce && do_push) begin
      mem[wr_r] <= i_din;
    end
  end

  // pointer and count update
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else if (i_ce) begin
      if (do_push) wr_r <= wrap_inc(wr_r);
      if (do_pop)  rd_r <= wrap_inc(rd_r);
      cnt_r <= cnt_r + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule

//--- rtl/urxe_pkg.sv
package urxe_pkg;
  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] ADDR_MODE_PRIMARY   = 8'h00;  // mode register one
  localparam logic [7:0] ADDR_MODE_SECONDARY = 8'h04;  // mode register two
  localparam logic [7:0] ADDR_STATUS         = 8'h08;  // channel status register
  localparam logic [7:0] ADDR_RX_DATA        = 8'h0C;  // read pops the fifo
  localparam logic [7:0] ADDR_COMMAND        = 8'h10;  // command strobes
  localparam logic [7:0] ADDR_INT_MASK       = 8'h14;  // interrupt mask register
  localparam logic [7:0] ADDR_INT_STATUS     = 8'h18;  // interrupt status register
  localparam logic [7:0] ADDR_MODE_VIEW      = 8'h1C;  // both modes + pointer, no side effect

  // ==========================================================================
  // reset values
  localparam logic [7:0] MODE_PRIMARY_RST    = 8'h00;
  localparam logic [7:0] MODE_SECONDARY_RST  = 8'h00;
  localparam logic [7:0] INT_MASK_RST        = 8'h00;

  // ==========================================================================
  // mode register one fields
  localparam int MP_RTS_CTRL   = 7;
  localparam int MP_INT_SEL    = 6;
  localparam int MP_ERR_MODE   = 5;
  localparam int MP_PAR_MODE_H = 4;
  localparam int MP_PAR_MODE_L = 3;
  localparam int MP_PAR_TYPE   = 2;
  localparam int MP_BITS_H     = 1;
  localparam int MP_BITS_L     = 0;

  // mode register two fields (stored for the transmitter side)
  localparam int MS_CHMODE_H   = 7;
  localparam int MS_CHMODE_L   = 6;
  localparam int MS_TX_RTS     = 5;
  localparam int MS_CTS_EN     = 4;
  localparam int MS_STOP_H     = 3;
  localparam int MS_STOP_L     = 0;

  // parity mode encodings
  localparam logic [1:0] PAR_WITH   = 2'h0;
  localparam logic [1:0] PAR_FORCE  = 2'h1;
  localparam logic [1:0] PAR_NONE   = 2'h2;
  localparam logic [1:0] PAR_MDROP  = 2'h3;

  // channel mode encodings
  localparam logic [1:0] CHM_NORMAL = 2'h0;
  localparam logic [1:0] CHM_ECHO   = 2'h1;
  localparam logic [1:0] CHM_LLOOP  = 2'h2;
  localparam logic [1:0] CHM_RLOOP  = 2'h3;

  // status register bits
  localparam int ST_BREAK   = 7;
  localparam int ST_FRAME   = 6;
  localparam int ST_PARITY  = 5;
  localparam int ST_OVERRUN = 4;
  localparam int ST_FULL    = 1;
  localparam int ST_READY   = 0;

  // interrupt status / mask bits for this channel
  localparam int IS_RX       = 1;
  localparam int IS_BRK_CHG  = 2;

  // command word bits
  localparam int CMD_PTR_REWIND = 0;
  localparam int CMD_ERR_RESET  = 1;
  localparam int CMD_BRK_CHG_CLR = 2;

  // ==========================================================================
  // timing: oversampling of the serial input
  localparam int OVERSAMPLE   = 16;
  localparam int START_SAMPLE = 7;
  localparam int FIFO_DEPTH   = 3;

  // fifo entry: character plus its own error flags
  typedef struct packed {
    logic       brk;
    logic       frame;
    logic       parity;
    logic [7:0] data;
  } urxe_entry_t;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

//--- sim/test_urxe_channel.sv
`timescale 1ns/1ps
// ==========================================
// channel bench: bus tasks, serial frames, queue model
module test_urxe_channel;
  logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [7:0]  aw = 8'h00, ar = 8'h00, m2, d, m2e;
  logic [31:0] wd = 32'h0, rd, rv_d;
  logic        awr, wr, bv, arr, rv, rts_n, rxi, bki, tick, line;
  int          n_errors = 0, n_tests = 0, k;
  logic [7:0]  q[$];
  always #2.5 clk = ~clk;
  urxe_far_tx src (.i_clk(clk), .o_tick(tick), .o_line(line));
  urxe_channel uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_rx_tick16(tick), .i_serial_rx_input(line),
    .o_request_to_send_n(rts_n), .o_rx_irq(rxi), .o_brk_irq(bki), .o_channel_mode_secondary(m2),
    .i_awaddr(aw), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr),
    .o_bresp(), .o_bvalid(bv), .i_bready(1'b1), .i_araddr(ar), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd),
    .o_rresp(), .o_rvalid(rv), .i_rready(1'b1));
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // ready is looked at mid-cycle, so each release lands just after the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    aw <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk); ta = awv & awr; tw = wv & wr; tb = bv;
      @(posedge clk); if (ta) awv <= 1'b0; if (tw) wv <= 1'b0; if (tb) break;
    end
    if (k == 40) begin n_errors++; report_and_stop(); end
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    logic ta, tr;
    ar <= a; arv <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk); ta = arv & arr; tr = rv; rv_d = rd;
      @(posedge clk); if (ta) arv <= 1'b0; if (tr) break;
    end
    if (k == 40) begin n_errors++; report_and_stop(); end
    chk(s, e, rv_d);
  endtask
  initial begin
    void'($urandom(65));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk("view", urxe_pkg::ADDR_MODE_VIEW, 32'h0);
    wr_reg(urxe_pkg::ADDR_MODE_PRIMARY, 32'hC3);
    m2e = $urandom;
    wr_reg(urxe_pkg::ADDR_MODE_SECONDARY, {24'h0, m2e});
    rchk("view", urxe_pkg::ADDR_MODE_VIEW, {15'h0, 1'b1, m2e, 8'hC3});
    chk("mode2", {24'h0, m2e}, {24'h0, m2});
    rchk("unmapped", 8'h20, 32'h0);
    wr_reg(urxe_pkg::ADDR_INT_MASK, 32'h6);
    // five even-parity frames: three fill the fifo, the fifth overwrites the held one
    for (int i = 0; i < 5; i++) begin
      d = $urandom;
      src.send({1'b1, ^d, d, 1'b0}, 11, 1'b1);
      if (q.size() == 4) q[3] = d; else q.push_back(d);
      rchk("status", urxe_pkg::ADDR_STATUS, i < 2 ? 1 : i < 4 ? 3 : 32'h13);
      chk("rx_irq", i >= 2, rxi);
      chk("rts_n", i >= 2, rts_n);
    end
    while (q.size() > 0) rchk("data", urxe_pkg::ADDR_RX_DATA, q.pop_front());
    wr_reg(urxe_pkg::ADDR_COMMAND, 32'h3);
    rchk("view", urxe_pkg::ADDR_MODE_VIEW, {16'h0, m2e, 8'hC3});
    // bad parity, then bad stop bit
    for (int j = 0; j < 2; j++) begin
      d = $urandom | 8'h01;
      src.send({j == 0, ^d ^ (j == 0), d, 1'b0}, 11, 1'b1);
      rchk("status", urxe_pkg::ADDR_STATUS, j ? 32'h41 : 32'h21);
      rchk("data", urxe_pkg::ADDR_RX_DATA, d);
    end
    src.send(12'h000, 12, 1'b0);
    rchk("isr", urxe_pkg::ADDR_INT_STATUS, 32'h4);
    chk("brk_irq", 1, bki);
    rchk("status", urxe_pkg::ADDR_STATUS, 32'hC1);
    wr_reg(urxe_pkg::ADDR_COMMAND, 32'h4);
    src.send(12'h001, 1, 1'b1);
    rchk("isr", urxe_pkg::ADDR_INT_STATUS, 32'h4);
    rchk("data", urxe_pkg::ADDR_RX_DATA, 32'h0);
    rchk("status", urxe_pkg::ADDR_STATUS, 32'h0);
    // block error mode: a popped bad-parity char stays flagged until error reset
    wr_reg(urxe_pkg::ADDR_COMMAND, 32'h3);
    wr_reg(urxe_pkg::ADDR_MODE_PRIMARY, 32'hE3);
    src.send({1'b1, ~^d, d, 1'b0}, 11, 1'b1);
    rchk("data", urxe_pkg::ADDR_RX_DATA, d);
    rchk("status", urxe_pkg::ADDR_STATUS, 32'h20);
    report_and_stop();
  end
endmodule

//--- sim/urxe_channel_monitor.sv
`timescale 1ns/1ps
// ==========================================
// bus answer checks at the channel ports
module urxe_channel_monitor (
  input wire logic        i_sys_clk,                // clock
  input wire logic        i_rst_n,                  // reset
  input wire logic        i_awvalid,                // aw valid
  input wire logic        o_awready,                // aw ready
  input wire logic        i_wvalid,                 // w valid
  input wire logic        o_wready,                 // w ready
  input wire logic        o_bvalid,                 // b valid
  input wire logic        i_bready,                 // b ready
  input wire logic        i_arvalid,                // ar valid
  input wire logic        o_arready,                // ar ready
  input wire logic        o_rvalid,                 // r valid
  input wire logic        i_rready,                 // r ready
  input wire logic [1:0]  o_rresp,                  // r resp
  input wire logic [31:0] o_rdata,                  // r data
  input wire logic [7:0]  o_channel_mode_secondary  // mode two
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wr_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid) else $error("no b");
  rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("no r");
  b_block_a: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken early");
  b_single_a: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("b held");
  r_single_a: assert property (o_rvalid && i_rready && !i_arvalid |=> !o_rvalid) else $error("r held");
  err_zero_a: assert property (o_rvalid && o_rresp == urxe_pkg::AXI_SLVERR |-> o_rdata == 32'h0) else $error("rd");
  rd_resp_a: assert property (o_rvalid |-> o_rresp inside {2'h0, 2'h2}) else $error("bad resp");
  mode_write_a: assert property ($changed(o_channel_mode_secondary) |-> ##[0:1] $rose(o_bvalid)) else $error("m2");
  cover property (o_rvalid && o_rresp == urxe_pkg::AXI_SLVERR);
  cover property ($changed(o_channel_mode_secondary));
  cover property (o_bvalid);
endmodule
bind urxe_channel urxe_channel_monitor mon (.*);

//--- sim/urxe_far_tx.sv
`timescale 1ns/1ps
// ==========================================
// far-end transmitter and 16x receive tick
module urxe_far_tx (
  input  wire logic i_clk,  // system clock
  output logic      o_tick, // 16x tick
  output logic      o_line  // serial line
);
  logic [1:0] div_r = 2'h0;
  initial o_line = 1'b1;
  // tick every fourth clock keeps frames short
  always @(posedge i_clk) div_r <= div_r + 2'h1;
  assign o_tick = (div_r == 2'h0);
  // bits go lsb first, sixteen ticks each; fin lets a break stay low
  task automatic send(input logic [11:0] b, input int n, input logic fin);
    for (int i = 0; i < n; i++) begin
      o_line <= b[i];
      repeat (16) @(posedge i_clk iff o_tick);
    end
    o_line <= fin;
  endtask
endmodule
